// ---- hdl/aht_timer.v ----
// aht_timer.v: phase timer; a phase loaded with n lasts max(n,1) cycles
// assumes: load_in is high in the first cycle of each phase
`timescale 1ns/1ps
module aht_timer #(parameter W = 9) (
   input wire clk_in,             // bus clock
   input wire rst_in,             // synchronous reset, active high
   input wire load_in,            // first cycle of a phase
   input wire [W-1:0] value_in,   // phase length in cycles
   output wire done_out           // last cycle of the phase
);
   reg [W-1:0] cnt_r;
   wire [W-1:0] one = {{(W-1){1'b0}}, 1'b1};

   assign done_out = load_in ? (value_in <= one) : (cnt_r <= one);

   always @(posedge clk_in) begin
      if (rst_in) begin
         cnt_r <= {W{1'b0}};
      end else if (load_in) begin
         cnt_r <= (value_in == {W{1'b0}}) ? {W{1'b0}} : value_in - one;
      end else if (cnt_r != {W{1'b0}}) begin
         cnt_r <= cnt_r - one;
      end
   end
endmodule

// ---- hdl/aht_top.v ----
// aht_top.v: ata host bus sequencer for pio, multiword dma and ultra dma
// assumes: pins reach the drive through a bidirectional buffer steered here
`timescale 1ns/1ps
`include "aht_defines.vh"
module aht_top #(parameter CW = 8) (
   input wire ref_clk_in,                    // bus clock
   input wire rst_in,                        // synchronous reset, active high
   input wire start_in,                      // pulse: begin a transfer
   input wire [2:0] mode_in,                 // transfer kind
   input wire [2:0] addr_in,                 // pio register address
   input wire [1:0] cs_sel_in,               // pio chip selects, active high
   input wire [15:0] word_count_in,          // dma words to move
   input wire stop_in,                       // level: host ends dma burst
   input wire [15:0] wr_data_in,             // word to send
   input wire wr_valid_in,                   // wr_data_in valid
   output wire wr_ready_out,                 // pulse: word taken
   output wire [15:0] rd_data_out,           // word received
   output wire rd_valid_out,                 // pulse: rd_data_out new
   output wire busy_out,                     // transfer in progress
   output wire done_out,                     // pulse: transfer ended
   input wire [CW-1:0] addr_setup_count_in,  // pio address setup
   input wire [CW-1:0] read_pulse_count_in,  // pio read strobe width
   input wire [CW-1:0] write_pulse_count_in, // pio write strobe width
   input wire [CW-1:0] addr_hold_count_in,   // pio address hold
   input wire [CW-1:0] data_hold_count_in,   // pio write data hold
   input wire [CW-1:0] ready_sample_count_in, // ready sample delay
   input wire [CW-1:0] read_sample_count_in, // read capture delay
   input wire [CW-1:0] dma_setup_count_in,   // mdma setup
   input wire [CW-1:0] dma_pulse_count_in,   // mdma strobe width
   input wire [CW-1:0] dma_recovery_count_in, // mdma recovery
   input wire [CW-1:0] ack_hold_count_in,    // mdma ack hold
   input wire [CW-1:0] buf_on_count_in,      // buffer turn-on
   input wire [CW-1:0] buf_off_count_in,     // buffer turn-off
   input wire [CW-1:0] ack_setup_count_in,   // udma ack setup
   input wire [CW-1:0] envelope_count_in,    // udma envelope
   input wire [CW-1:0] ready_pause_count_in, // udma in pause
   input wire [CW-1:0] interlock_count_in,   // udma interlock
   input wire [CW-1:0] bus_release_count_in, // udma bus release
   input wire [CW-1:0] ctrl_hold_count_in,   // udma control hold
   input wire [CW-1:0] data_setup_count_in,  // udma out data setup
   input wire [CW-1:0] udma_data_hold_count_in, // udma out data hold
   input wire [CW-1:0] cycle_count_in,       // udma out half cycle
   input wire [CW-1:0] strobe_stop_count_in, // udma out strobe to stop
   output wire [1:0] ata_cs_n_out,           // chip selects, active low
   output wire [2:0] ata_addr_out,           // register address
   output wire ata_rd_n_out,                 // read strobe / ready / hstrobe
   output wire ata_wr_n_out,                 // write strobe / stop
   output wire ata_ack_n_out,                // dma acknowledge, active low
   output wire [15:0] ata_data_out,          // data driven by host
   output wire ata_data_oe_n_out,            // low while host drives data
   input wire [15:0] ata_data_in,            // data pins
   input wire ata_ready_in,                  // ready / drive strobe / pause
   input wire ata_req_in,                    // dma request
   output wire ata_buf_dir_out               // buffer direction
);
   localparam EW = CW + 2;
   localparam TW = CW + 1;
   localparam [14:0] S_IDLE = 15'h0001, S_BON = 15'h0002, S_SET = 15'h0004;
   localparam [14:0] S_STB = 15'h0008, S_HLD = 15'h0010, S_REC = 15'h0020;
   localparam [14:0] S_AKH = 15'h0040, S_BOFF = 15'h0080, S_UACK = 15'h0100;
   localparam [14:0] S_UENV = 15'h0200, S_UXF = 15'h0400, S_UPAU = 15'h0800;
   localparam [14:0] S_USTP = 15'h1000, S_UZAH = 15'h2000, S_UCVH = 15'h4000;

   reg [14:0] state_r;
   reg entry_r;
   reg [EW-1:0] elapsed_r;
   reg [2:0] mode_r;
   reg [15:0] words_r;
   reg [1:0] cs_n_r;
   reg [2:0] addr_r;
   reg rd_n_r, wr_n_r, ack_n_r, doe_n_r, bdir_r;
   reg [15:0] dout_r, rdata_r;
   reg rvalid_r, done_r;
   reg rdy_seen_r, cap_done_r;
   reg [EW-1:0] rdy_cnt_r;
   reg [TW-1:0] ucnt_r, ld_cnt_r;
   reg word_ok_r;
   reg [1:0] gap_r;
   reg ready_m_r, ready_s_r, ready_p_r, req_m_r, req_s_r;
   reg [15:0] data_m_r, data_s_r;
   reg [TW-1:0] tmr_val;
   wire tmr_done;

   wire is_pio = (mode_r == `AHT_MODE_PIO_RD) | (mode_r == `AHT_MODE_PIO_WR);
   wire is_mdma = (mode_r == `AHT_MODE_MDMA_RD) | (mode_r == `AHT_MODE_MDMA_WR);
   wire is_out = mode_r[0];
   // saturating successors: a counter parked at all ones must not read back as zero
   wire [EW-1:0] el1 = (elapsed_r == {EW{1'b1}}) ? elapsed_r : elapsed_r + 1'b1;
   wire [TW-1:0] u1 = (ucnt_r == {TW{1'b1}}) ? ucnt_r : ucnt_r + 1'b1;
   wire [TW-1:0] ld1 = (ld_cnt_r == {TW{1'b1}}) ? ld_cnt_r : ld_cnt_r + 1'b1;
   wire [CW-1:0] pio_pulse = is_out ? write_pulse_count_in : read_pulse_count_in;
   wire [CW-1:0] akh_cnt = (dma_recovery_count_in > ack_hold_count_in) ?
                           dma_recovery_count_in : ack_hold_count_in;
   wire more = (words_r != 16'h0000) & req_s_r & ~stop_in;
   wire mdma_go = is_mdma & (state_r == S_SET | state_r == S_REC) & tmr_done & more &
                  (~is_out | wr_valid_in);
   wire uload = (state_r == S_UXF) & is_out & ~word_ok_r & more &
                (u1 >= {1'b0, udma_data_hold_count_in}) & wr_valid_in;
   wire uedge = (state_r == S_UXF) & is_out & word_ok_r & ~ready_s_r &
                (ld1 >= {1'b0, data_setup_count_in}) & (u1 >= {1'b0, cycle_count_in});
   wire uend_out = (state_r == S_UXF) & is_out & ~more &
                   (u1 >= {1'b0, strobe_stop_count_in});
   wire uend_in = (state_r == S_UXF) & ~is_out & ~more;
   wire edge_in = ~is_out & (state_r == S_UXF | state_r == S_UPAU) &
                  (ready_s_r ^ ready_p_r);
   wire pio_take = (state_r == S_IDLE) & start_in & (mode_in == `AHT_MODE_PIO_WR);

   assign wr_ready_out = pio_take | (mdma_go & is_out) | uload;
   assign rd_data_out = rdata_r;
   assign rd_valid_out = rvalid_r;
   assign busy_out = (state_r != S_IDLE);
   assign done_out = done_r;
   assign ata_cs_n_out = cs_n_r;
   assign ata_addr_out = addr_r;
   assign ata_rd_n_out = rd_n_r;
   assign ata_wr_n_out = wr_n_r;
   assign ata_ack_n_out = ack_n_r;
   assign ata_data_out = dout_r;
   assign ata_data_oe_n_out = doe_n_r;
   assign ata_buf_dir_out = bdir_r;

   // phase lengths, one per timed state
   always @* begin
      case (state_r)
         S_BON: tmr_val = {1'b0, buf_on_count_in};
         S_SET: tmr_val = {1'b0, is_pio ? addr_setup_count_in : dma_setup_count_in};
         S_STB: tmr_val = {1'b0, dma_pulse_count_in};
         S_REC: tmr_val = {1'b0, dma_recovery_count_in};
         S_AKH: tmr_val = {1'b0, akh_cnt};
         S_BOFF: tmr_val = {1'b0, buf_off_count_in};
         S_UACK: tmr_val = {1'b0, ack_setup_count_in};
         S_UENV: tmr_val = {1'b0, envelope_count_in};
         S_UPAU: tmr_val = {1'b0, ready_pause_count_in};
         S_USTP: tmr_val = {1'b0, interlock_count_in} + `AHT_MLI_EXTRA;
         S_UZAH: tmr_val = {1'b0, bus_release_count_in} + `AHT_MLI_EXTRA;
         S_UCVH: tmr_val = {1'b0, ctrl_hold_count_in};
         default: tmr_val = {TW{1'b0}};
      endcase
   end

   aht_timer #(.W(TW)) u_phase (
      .clk_in(ref_clk_in),
      .rst_in(rst_in),
      .load_in(entry_r),
      .value_in(tmr_val),
      .done_out(tmr_done)
   );

   // pins from the drive pass two flops first
   always @(posedge ref_clk_in) begin
      if (rst_in) begin
         ready_m_r <= 1'b0;
         ready_s_r <= 1'b0;
         ready_p_r <= 1'b0;
         req_m_r <= 1'b0;
         req_s_r <= 1'b0;
         data_m_r <= 16'h0000;
         data_s_r <= 16'h0000;
      end else begin
         ready_m_r <= ata_ready_in;
         ready_s_r <= ready_m_r;
         ready_p_r <= ready_s_r;
         req_m_r <= ata_req_in;
         req_s_r <= req_m_r;
         data_m_r <= ata_data_in;
         data_s_r <= data_m_r;
      end
   end

   always @(posedge ref_clk_in) begin
      if (rst_in) begin
         state_r <= S_IDLE;
         entry_r <= 1'b0;
         elapsed_r <= {EW{1'b0}};
         mode_r <= `AHT_MODE_PIO_RD;
         words_r <= 16'h0000;
         cs_n_r <= 2'h3;
         addr_r <= 3'h0;
         rd_n_r <= 1'b1;
         wr_n_r <= 1'b1;
         ack_n_r <= 1'b1;
         doe_n_r <= 1'b1;
         bdir_r <= 1'b0;
         dout_r <= 16'h0000;
         rdata_r <= 16'h0000;
         rvalid_r <= 1'b0;
         done_r <= 1'b0;
         rdy_seen_r <= 1'b0;
         cap_done_r <= 1'b0;
         rdy_cnt_r <= {EW{1'b0}};
         ucnt_r <= `AHT_UCNT_INIT;
         ld_cnt_r <= {TW{1'b0}};
         word_ok_r <= 1'b0;
         gap_r <= 2'h0;
      end else begin
         entry_r <= 1'b0;
         rvalid_r <= 1'b0;
         done_r <= 1'b0;
         if (elapsed_r != {EW{1'b1}})
            elapsed_r <= el1;
         if (ucnt_r != {TW{1'b1}})
            ucnt_r <= u1;
         if (ld_cnt_r != {TW{1'b1}})
            ld_cnt_r <= ld1;
         if (edge_in) begin
            gap_r <= 2'h0;
            rdata_r <= data_s_r;
            rvalid_r <= 1'b1;
            if (words_r != 16'h0000)
               words_r <= words_r - 16'h0001;
         end else if (gap_r != `AHT_STOP_GAP) begin
            gap_r <= gap_r + 2'h1;
         end
         case (state_r)
            S_IDLE: begin
               if (start_in) begin
                  mode_r <= mode_in;
                  words_r <= word_count_in;
                  entry_r <= 1'b1;
                  elapsed_r <= {EW{1'b0}};
                  if (pio_take)
                     dout_r <= wr_data_in;
                  if (mode_in[0]) begin
                     bdir_r <= 1'b1;
                     state_r <= S_BON;
                  end else if (mode_in[2]) begin
                     state_r <= S_UACK;
                  end else begin
                     state_r <= S_SET;
                  end
                  if (mode_in[2:1] == 2'b00) begin
                     cs_n_r <= ~cs_sel_in;
                     addr_r <= addr_in;
                  end else if (mode_in[2:1] == 2'b01) begin
                     ack_n_r <= 1'b0;
                  end
               end
            end
            S_BON: begin
               if (tmr_done) begin
                  doe_n_r <= 1'b0;
                  entry_r <= 1'b1;
                  state_r <= mode_r[2] ? S_UACK : S_SET;
               end
            end
            S_SET, S_REC: begin
               if (is_pio & tmr_done) begin
                  if (is_out)
                     wr_n_r <= 1'b0;
                  else
                     rd_n_r <= 1'b0;
                  rdy_seen_r <= 1'b0;
                  cap_done_r <= 1'b0;
                  entry_r <= 1'b1;
                  elapsed_r <= {EW{1'b0}};
                  state_r <= S_STB;
               end else if (mdma_go) begin
                  // request sampled afresh before each word
                  if (is_out) begin
                     dout_r <= wr_data_in;
                     wr_n_r <= 1'b0;
                  end else begin
                     rd_n_r <= 1'b0;
                  end
                  entry_r <= 1'b1;
                  state_r <= S_STB;
               end else if (is_mdma & tmr_done & (stop_in | words_r == 16'h0000)) begin
                  entry_r <= 1'b1;
                  state_r <= S_AKH;
               end
            end
            S_STB: begin
               if (is_pio) begin
                  if (~rdy_seen_r & ready_s_r &
                      (elapsed_r >= {2'b00, ready_sample_count_in} + `AHT_RDY_EXTRA)) begin
                     rdy_seen_r <= 1'b1;
                     rdy_cnt_r <= {{(EW-1){1'b0}}, 1'b1};
                  end else if (rdy_seen_r & (rdy_cnt_r != {EW{1'b1}})) begin
                     rdy_cnt_r <= rdy_cnt_r + 1'b1;
                  end
                  if (~is_out & rdy_seen_r & ~cap_done_r &
                      (rdy_cnt_r >= {2'b00, read_sample_count_in})) begin
                     rdata_r <= data_s_r;
                     rvalid_r <= 1'b1;
                     cap_done_r <= 1'b1;
                  end
                  if ((el1 >= {2'b00, pio_pulse}) & rdy_seen_r & (is_out | cap_done_r)) begin
                     rd_n_r <= 1'b1;
                     wr_n_r <= 1'b1;
                     entry_r <= 1'b1;
                     elapsed_r <= {EW{1'b0}};
                     state_r <= S_HLD;
                  end
               end else if (tmr_done) begin
                  rd_n_r <= 1'b1;
                  wr_n_r <= 1'b1;
                  if (~is_out) begin
                     rdata_r <= data_s_r;
                     rvalid_r <= 1'b1;
                  end
                  words_r <= words_r - 16'h0001;
                  entry_r <= 1'b1;
                  state_r <= (words_r == 16'h0001) ? S_AKH : S_REC;
               end
            end
            S_HLD: begin
               if (is_out & (el1 >= {2'b00, data_hold_count_in}))
                  doe_n_r <= 1'b1;
               if ((el1 >= {2'b00, addr_hold_count_in}) &
                   (~is_out | el1 >= {2'b00, data_hold_count_in})) begin
                  cs_n_r <= 2'h3;
                  entry_r <= 1'b1;
                  if (is_out) begin
                     state_r <= S_BOFF;
                  end else begin
                     done_r <= 1'b1;
                     state_r <= S_IDLE;
                  end
               end
            end
            S_AKH: begin
               if (tmr_done) begin
                  ack_n_r <= 1'b1;
                  doe_n_r <= 1'b1;
                  entry_r <= 1'b1;
                  if (is_out) begin
                     state_r <= S_BOFF;
                  end else begin
                     done_r <= 1'b1;
                     state_r <= S_IDLE;
                  end
               end
            end
            S_BOFF: begin
               if (tmr_done) begin
                  bdir_r <= 1'b0;
                  done_r <= 1'b1;
                  state_r <= S_IDLE;
               end
            end
            S_UACK: begin
               if (tmr_done) begin
                  ack_n_r <= 1'b0;
                  entry_r <= 1'b1;
                  state_r <= S_UENV;
               end
            end
            S_UENV: begin
               if (tmr_done) begin
                  wr_n_r <= 1'b0;
                  rd_n_r <= is_out;
                  ucnt_r <= `AHT_UCNT_INIT;
                  word_ok_r <= 1'b0;
                  entry_r <= 1'b1;
                  state_r <= S_UXF;
               end
            end
            S_UXF: begin
               if (uedge) begin
                  rd_n_r <= ~rd_n_r;
                  ucnt_r <= {TW{1'b0}};
                  word_ok_r <= 1'b0;
                  words_r <= words_r - 16'h0001;
               end else if (uload) begin
                  dout_r <= wr_data_in;
                  ld_cnt_r <= {TW{1'b0}};
                  word_ok_r <= 1'b1;
               end else if (uend_out) begin
                  wr_n_r <= 1'b1;
                  entry_r <= 1'b1;
                  state_r <= S_USTP;
               end else if (uend_in) begin
                  rd_n_r <= 1'b1;
                  entry_r <= 1'b1;
                  state_r <= S_UPAU;
               end
            end
            S_UPAU: begin
               if (tmr_done & (gap_r == `AHT_STOP_GAP) & ~edge_in) begin
                  wr_n_r <= 1'b1;
                  entry_r <= 1'b1;
                  state_r <= S_USTP;
               end
            end
            S_USTP: begin
               if (tmr_done) begin
                  entry_r <= 1'b1;
                  state_r <= is_out ? S_UCVH : S_UZAH;
               end
            end
            S_UZAH: begin
               if (tmr_done) begin
                  entry_r <= 1'b1;
                  state_r <= S_UCVH;
               end
            end
            S_UCVH: begin
               if (tmr_done) begin
                  ack_n_r <= 1'b1;
                  rd_n_r <= 1'b1;
                  wr_n_r <= 1'b1;
                  doe_n_r <= 1'b1;
                  entry_r <= 1'b1;
                  if (is_out) begin
                     state_r <= S_BOFF;
                  end else begin
                     done_r <= 1'b1;
                     state_r <= S_IDLE;
                  end
               end
            end
            default: begin
               state_r <= S_IDLE;
            end
         endcase
      end
   end
   // all counts are read live and must stay steady while busy_out is high
endmodule

// ---- pkg/aht_defines.vh ----
// aht_defines.vh: constants shared by the ata host timing sequencer
// assumes: included by bare name from files under hdl/
`ifndef AHT_DEFINES_VH
`define AHT_DEFINES_VH

// transfer kinds; bit 0 set means host-to-drive
`define AHT_MODE_PIO_RD 3'h0
`define AHT_MODE_PIO_WR 3'h1
`define AHT_MODE_MDMA_RD 3'h2
`define AHT_MODE_MDMA_WR 3'h3
`define AHT_MODE_UDMA_IN 3'h4
`define AHT_MODE_UDMA_OUT 3'h5

// ready sampling offset of 1.5 periods, rounded up to whole cycles
`define AHT_RDY_EXTRA 10'h002
// interlock and bus release offset of 0.4 period, rounded up
`define AHT_MLI_EXTRA 9'h001
// cycles between the last drive strobe edge and stop
`define AHT_STOP_GAP 2'h3
// reset value of the udma edge spacing counter (saturated)
`define AHT_UCNT_INIT 9'h1ff

`endif

// ---- testbench/aht_assertions.sv ----
// aht_assertions.sv: pin timing checks for the ata host sequencer
// assumes: bound to aht_top, counts held steady while busy
`timescale 1ns/1ps
module aht_chk #(parameter CW = 8) (
   input wire ref_clk_in, // clock
   input wire rst_in, // reset
   input wire [1:0] ata_cs_n_out, // selects
   input wire ata_rd_n_out, // read strobe
   input wire ata_wr_n_out, // write strobe
   input wire ata_ack_n_out, // acknowledge
   input wire [15:0] ata_data_out, // host data
   input wire ata_data_oe_n_out, // data enable
   input wire ata_buf_dir_out, // buffer direction
   input wire ata_ready_in, // drive strobe
   input wire [CW-1:0] read_pulse_count_in, // read width
   input wire [CW-1:0] write_pulse_count_in // write width
);
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (rst_in);
   reg [7:0] low_r;
   wire pio = ata_ack_n_out;
   wire stb = ata_rd_n_out & ata_wr_n_out;
   // cycles the strobe has been low so far
   always @(posedge ref_clk_in) low_r <= stb ? 8'h00 : ((low_r == 8'hff) ? low_r : low_r + 8'h01);
   property p_dir; !ata_data_oe_n_out |-> ata_buf_dir_out; endproperty
   a_dir: assert property (p_dir) else $error("drive with buffer inward");
   property p_set; $fell(stb) && pio |-> $past(ata_cs_n_out) != 2'h3; endproperty
   a_set: assert property (p_set) else $error("no select setup");
   property p_rdw; $rose(ata_rd_n_out) && pio |-> low_r >= read_pulse_count_in; endproperty
   a_rdw: assert property (p_rdw) else $error("read strobe short");
   property p_wrw; $rose(ata_wr_n_out) && pio |-> low_r >= write_pulse_count_in; endproperty
   a_wrw: assert property (p_wrw) else $error("write strobe short");
   property p_hold; $rose(stb) && pio |-> ata_cs_n_out == $past(ata_cs_n_out); endproperty
   a_hold: assert property (p_hold) else $error("select not held");
   property p_dh; $rose(ata_wr_n_out) && pio |-> $stable(ata_data_out); endproperty
   a_dh: assert property (p_dh) else $error("write data not held");
   property p_env; $fell(ata_ack_n_out) |-> ata_rd_n_out && ata_wr_n_out; endproperty
   a_env: assert property (p_env) else $error("no envelope");
   property p_stop; $rose(ata_wr_n_out) && !ata_ack_n_out && ata_data_oe_n_out
      |-> $past(ata_ready_in, 4) == $past(ata_ready_in, 5); endproperty
   a_stop: assert property (p_stop) else $error("stop too early");
endmodule
bind aht_top aht_chk #(.CW(CW)) aht_chk_i (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .ata_cs_n_out(ata_cs_n_out),
   .ata_rd_n_out(ata_rd_n_out), .ata_wr_n_out(ata_wr_n_out), .ata_ack_n_out(ata_ack_n_out),
   .ata_data_out(ata_data_out), .ata_data_oe_n_out(ata_data_oe_n_out), .ata_buf_dir_out(ata_buf_dir_out),
   .ata_ready_in(ata_ready_in), .read_pulse_count_in(read_pulse_count_in),
   .write_pulse_count_in(write_pulse_count_in));

// ---- testbench/aht_drive_model.sv ----
// aht_drive_model.sv: behavioural disk drive beyond the bus
// assumes: active low strobes; 800 ns link clock runs only in a udma in burst
`timescale 1ns/1ps
module aht_drive_model (
   input wire rd_n_in, // read strobe
   input wire wr_n_in, // write strobe
   input wire ack_n_in, // acknowledge
   input wire oe_n_in, // host data enable
   output reg ready_out, // ready or drive strobe
   output wire [15:0] data_out // drive data
);
   reg [15:0] val_r = 16'h3c5a;
   wire burst = !ack_n_in && !rd_n_in && !wr_n_in && oe_n_in;
   // released bus shows the inverse of the last word
   assign data_out = (burst || (oe_n_in && !rd_n_in && wr_n_in)) ? val_r : ~val_r;
   initial ready_out = 1'b1;
   // only an outgoing burst (host drives data) unpauses; an incoming burst keeps the strobe idle high
   always @(negedge ack_n_in) if (!oe_n_in) ready_out = 1'b0;
   always @(posedge ack_n_in) ready_out = 1'b1;
   always @(negedge rd_n_in or negedge wr_n_in) if (ack_n_in === 1'b1) begin
      ready_out = 1'b0;
      #350 ready_out = 1'b1;
   end
   always @(posedge rd_n_in) if (ack_n_in === 1'b0) val_r = val_r + 16'h0001;
   always #400 if (burst) begin
      val_r = val_r + 16'h1111;
      ready_out = ~ready_out;
   end
endmodule

// ---- testbench/testbench.sv ----
// testbench.sv: self-checking bench for the ata host sequencer
// assumes: drive model on the far side, small fixed counts
`timescale 1ns/1ps
module testbench;
   reg ref_clk_in = 1'b0, rst_in = 1'b1, start_in = 1'b0, stop_in = 1'b0, wv = 1'b1, req = 1'b1;
   reg [2:0] mode_in = 3'h0;
   reg [15:0] words = 16'h0000, wd = 16'h1234;
   reg [7:0] k2 = 8'h02, k3 = 8'h03;
   wire wr_ready_out, rd_valid_out, busy_out, done_out, rd_n, wr_n, ack_n, oe_n, rdy, bdir;
   wire [15:0] rd_data_out, din, dout;
   wire [1:0] cs_n;
   wire [2:0] addr;
   reg [15:0] sel_seen = 16'h0000, wr_seen = 16'h0000;
   integer miscompares = 0, cmp_count = 0, cyc = 0, nrd = 0, nwr = 0;
   always #50 ref_clk_in = ~ref_clk_in;
   aht_top aht_top_i (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .start_in(start_in), .mode_in(mode_in),
      .addr_in(3'h5), .cs_sel_in(2'h1), .word_count_in(words), .stop_in(stop_in), .wr_data_in(wd),
      .wr_valid_in(wv), .wr_ready_out(wr_ready_out), .rd_data_out(rd_data_out), .rd_valid_out(rd_valid_out),
      .busy_out(busy_out), .done_out(done_out), .addr_setup_count_in(k2), .read_pulse_count_in(k3),
      .write_pulse_count_in(k3), .addr_hold_count_in(k2), .data_hold_count_in(k2), .ready_sample_count_in(k2),
      .read_sample_count_in(k2), .dma_setup_count_in(k2), .dma_pulse_count_in(k3), .dma_recovery_count_in(k2),
      .ack_hold_count_in(k3), .buf_on_count_in(k2), .buf_off_count_in(k2), .ack_setup_count_in(k2),
      .envelope_count_in(k2), .ready_pause_count_in(k3), .interlock_count_in(k2), .bus_release_count_in(k2),
      .ctrl_hold_count_in(k2), .data_setup_count_in(k2), .udma_data_hold_count_in(k2), .cycle_count_in(k3),
      .strobe_stop_count_in(k3), .ata_cs_n_out(cs_n), .ata_addr_out(addr), .ata_rd_n_out(rd_n),
      .ata_wr_n_out(wr_n),
      .ata_ack_n_out(ack_n), .ata_data_out(dout), .ata_data_oe_n_out(oe_n), .ata_data_in(din),
      .ata_ready_in(rdy), .ata_req_in(req), .ata_buf_dir_out(bdir));
   aht_drive_model aht_drive_model_i (.rd_n_in(rd_n), .wr_n_in(wr_n), .ack_n_in(ack_n), .oe_n_in(oe_n),
      .ready_out(rdy), .data_out(din));
   task check(input [15:0] seen, input [15:0] exp);
      begin
         cmp_count = cmp_count + 1;
         if (seen !== exp) begin
            miscompares = miscompares + 1;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
         end
      end
   endtask
   task end_of_test;
      begin
         $display("compares=%0d mismatches=%0d", cmp_count, miscompares);
         if (miscompares == 0 && cmp_count > 0) $display("*** PASS ***");
         else $display("*** FAIL ***");
         $finish;
      end
   endtask
   // count words moved each way; cut a hang short
   always @(posedge ref_clk_in) begin
      nrd = nrd + rd_valid_out;
      nwr = nwr + wr_ready_out;
      // selects and write data as the drive sees them while a pio strobe is low
      if (!(rd_n & wr_n) & ack_n) sel_seen = {11'h000, cs_n, addr};
      if (!wr_n & ack_n) wr_seen = dout;
      cyc = cyc + 1;
      if (cyc == 20000) begin
         miscompares = miscompares + 1;
         end_of_test;
      end
   end
   task xfer(input [2:0] m, input [15:0] n);
      integer t;
      begin
         mode_in = m;
         words = n;
         start_in = 1'b1;
         nrd = 0;
         nwr = 0;
         @(negedge ref_clk_in) start_in = 1'b0;
         for (t = 0; t < 600 && done_out !== 1'b1; t = t + 1) @(negedge ref_clk_in);
         @(negedge ref_clk_in);
         check({15'h0000, busy_out}, 16'h0000);
      end
   endtask
   task t_pio;
      begin
         xfer(3'h0, 16'h0000);
         check(rd_data_out, 16'h3c5a);
         check(nrd[15:0], 16'h0001);
         check(sel_seen, 16'h0015);
         xfer(3'h1, 16'h0000);
         check(nwr[15:0], 16'h0001);
         check(wr_seen, 16'h1234);
         check({15'h0000, bdir}, 16'h0000);
      end
   endtask
   task t_dma;
      begin
         xfer(3'h2, 16'h0003);
         check(nrd[15:0], 16'h0003);
         xfer(3'h3, 16'h0002);
         check(nwr[15:0], 16'h0002);
      end
   endtask
   task t_udma;
      begin
         xfer(3'h4, 16'h0003);
         check(nrd[15:0], 16'h0003);
         xfer(3'h5, 16'h0003);
         check(nwr[15:0], 16'h0003);
      end
   endtask
   initial begin
      repeat (10) @(negedge ref_clk_in);
      rst_in = 1'b0;
      @(negedge ref_clk_in);
      t_pio;
      t_dma;
      t_udma;
      end_of_test;
   end
endmodule
